// *** core/dsc_params.svh ***
// constants for the drive sequencer command and status block
`ifndef DSC_PARAMS_SVH
`define DSC_PARAMS_SVH
`define DSC_C_SWON 0
`define DSC_C_ENVOLT 1
`define DSC_C_NQS 2
`define DSC_C_ENOP 3
`define DSC_C_FRST 7
`define DSC_C_NETCMD 10
`define DSC_C_NETREF 11
`define DSC_C_JOG 12
`define DSC_C_REV 13
`define DSC_C_AUTOI 14
`define DSC_C_EDGEOP 15
`define DSC_S_RDY 0
`define DSC_S_SWON 1
`define DSC_S_OPEN 2
`define DSC_S_FLT 3
`define DSC_S_VOLT 4
`define DSC_S_NQS 5
`define DSC_S_DIS 6
`define DSC_S_NET 9
`define DSC_S_JOG 12
`define DSC_S_REV 13
`define DSC_S_REF 14
`define DSC_S_STOP 15
`define DSC_SAFE_MASK 16'h0007
`define DSC_CMD_RST 16'h0000
`define DSC_STAT_RST 16'h0000
`endif

// *** core/dsc_pkg.sv ***
// types for the drive sequencer command and status block
`default_nettype none
package dsc_pkg;
	typedef enum logic [2:0] { // RQ25
		DSC_NOT_READY = 3'b000,
		DSC_SW_DISABLED = 3'b001,
		DSC_READY = 3'b010,
		DSC_SWITCHED_ON = 3'b011,
		DSC_OP_ENABLED = 3'b100,
		DSC_QSTOP = 3'b101,
		DSC_FAULT_REACT = 3'b110,
		DSC_FAULTED = 3'b111
	} dsc_state_t;
	typedef enum logic [1:0] {
		DSC_SRC_APP = 2'b00,
		DSC_SRC_NET = 2'b01,
		DSC_SRC_KEYPAD = 2'b10
	} dsc_src_t;
	typedef struct packed {
		logic edge_run_required;
		logic auto_init;
		logic reverse;
		logic jog;
		logic net_ref;
		logic net_cmd;
		logic [1:0] spare;
		logic fault_reset;
		logic [2:0] ramp_ctl;
		logic enable_op;
		logic emergency_stop_inhibit;
		logic coast_stop_inhibit;
		logic power_up_request;
	} dsc_cmd_t;
endpackage : dsc_pkg
`default_nettype wire

// *** core/dsc_core.sv ***
// sequencer command word selection, command decode and status word
// Overview of operation
// RQ1 - effective command is read-only, taken from network, application or keypad
// RQ2 - network word used with bits 0 to 2 ANDed with application word
// RQ3 - application channel passes the application word straight through
// RQ4 - keypad supplies the word except bits 0 to 2 from application
// RQ5 - bit 0 one requests switch on, zero withdraws it
// RQ6 - bit 1 zero commands coast stop by removing voltage enable
// RQ7 - bit 2 zero commands emergency quickstop
// RQ8 - controller writes ones to reserved ramp bits 4, 5 and 6
// RQ9 - trips reset only on a rising edge of bit 7
// RQ10 - bit 10 selects network command word, status bit 9 shows it
// RQ11 - bit 11 selects network reference, status bit 14 shows it
// RQ12 - bit 12 with bit 3 runs jog, status bit 12 flags it
// RQ13 - bit 13 runs reverse when enabled, status bit 13 flags it
// RQ14 - bit 14 allows disabled to ready regardless of bit 0
// RQ15 - bit 15 demands rising edge of bit 3 to enable operation
// RQ16 - controller may use the example command values for stop, run, faults
// RQ17 - status word always readable whatever the command channel
// RQ18 - status bit 0 set when initialised and not configuring
// RQ19 - status bit 1 set in switched on or operation enabled
// RQ20 - status bit 5 zero while reacting to quickstop
// RQ21 - status bit 6 set exactly in switch on disabled
// RQ22 - status bit 15 set when run withdrawn or quickstop active
// RQ23 - status bits 2, 3, 4 show running, fault, supply present
// RQ24 - command bits 8, 9 ignored; status bits 7, 8, 10, 11 zero
// RQ25 - sequencer state encoded 0 to 7 in documented order
// RQ26 - fault reset leaves faulted only when no faults remain
`timescale 1ns/1ps
`default_nettype none
`include "dsc_params.svh"
module dsc_core (
	input wire logic CLK_SYS,
	input wire logic NRST,
	input wire logic LOCAL_KEYPAD_SEL,
	input wire logic [15:0] NET_CMD,
	input wire logic [15:0] APP_CMD,
	input wire logic [15:0] LOCAL_KEYPAD_CMD,
	input wire dsc_pkg::dsc_state_t SEQ_STATE,
	input wire logic INIT_DONE,
	input wire logic CONFIG_MODE,
	input wire logic SUPPLY_SENSE,
	input wire logic FAULT_ACTIVE,
	output logic [15:0] EFFECTIVE_SEQUENCER_COMMAND,
	output logic [15:0] SEQUENCER_STATE_FLAGS,
	output dsc_pkg::dsc_src_t CMD_SOURCE,
	output logic FAULT_RESET_PULSE,
	output logic FAULT_CLEAR,
	output logic POWER_UP_REQUEST,
	output logic COAST_STOP,
	output logic EMERGENCY_STOP,
	output logic ALLOW_READY,
	output logic ENABLE_OP_GO,
	output logic NET_REF_SEL,
	output logic JOG_RUN,
	output logic REVERSE_RUN
);
	localparam logic [15:0] SAFE = `DSC_SAFE_MASK;

	dsc_pkg::dsc_src_t src_nxt;
	dsc_pkg::dsc_src_t src_r;
	logic [15:0] cmd_nxt;
	dsc_pkg::dsc_cmd_t eff_r;
	dsc_pkg::dsc_cmd_t prev_r;
	logic [15:0] stat_nxt;
	logic [15:0] stat_r;
	logic sup1_r;
	logic sup2_r;
	logic sup3_r;
	logic supply_r;
	logic fault_pulse_r;
	logic fault_clear_r;
	logic swon_r;
	logic coast_r;
	logic estop_r;
	logic allow_ready_r;
	logic op_go_r;
	logic net_ref_r;
	logic jog_r;
	logic rev_r;
	logic rise_frst;
	logic rise_enop;
	logic safe_ok;
	logic op_req;
	logic in_op;

	// channel select: keypad wins, then network when the app asks for it
	always_comb begin
		if (LOCAL_KEYPAD_SEL) begin
			src_nxt = dsc_pkg::DSC_SRC_KEYPAD;
		end else if (APP_CMD[`DSC_C_NETCMD]) begin // RQ10
			src_nxt = dsc_pkg::DSC_SRC_NET;
		end else begin
			src_nxt = dsc_pkg::DSC_SRC_APP;
		end
	end

	always_comb begin
		case (src_nxt)
			dsc_pkg::DSC_SRC_NET: begin
				cmd_nxt = (NET_CMD & ~SAFE) | (NET_CMD & APP_CMD & SAFE); // RQ2
			end
			dsc_pkg::DSC_SRC_KEYPAD: begin
				cmd_nxt = (LOCAL_KEYPAD_CMD & ~SAFE) | (APP_CMD & SAFE); // RQ4
			end
			default: begin
				cmd_nxt = APP_CMD; // RQ3
			end
		endcase
	end

	// effective word loads from the selected channel, bits 0 to 2 ANDed with (network) or taken from (keypad) the application word
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			eff_r <= `DSC_CMD_RST;
			prev_r <= `DSC_CMD_RST;
			src_r <= dsc_pkg::DSC_SRC_APP;
		end else begin
			eff_r <= cmd_nxt; // RQ1
			prev_r <= eff_r;
			src_r <= src_nxt;
		end
	end

	// supply sense pin: three stages, accept when last two agree
	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			sup1_r <= 1'b0;
			sup2_r <= 1'b0;
			sup3_r <= 1'b0;
			supply_r <= 1'b0;
		end else begin
			sup1_r <= SUPPLY_SENSE;
			sup2_r <= sup1_r;
			sup3_r <= sup2_r;
			if (sup2_r == sup3_r) begin
				supply_r <= sup3_r;
			end
		end
	end

	// ramp bits 4..6 and spare bits 8..9 carry no decode
	assign rise_frst = eff_r.fault_reset & ~prev_r.fault_reset;
	assign rise_enop = eff_r.enable_op & ~prev_r.enable_op;
	assign safe_ok = eff_r.coast_stop_inhibit & eff_r.emergency_stop_inhibit;
	assign op_req = eff_r.edge_run_required ? rise_enop : eff_r.enable_op;
	assign in_op = (SEQ_STATE == dsc_pkg::DSC_OP_ENABLED);

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			fault_pulse_r <= 1'b0;
			fault_clear_r <= 1'b0;
		end else begin
			fault_pulse_r <= rise_frst; // RQ9
			fault_clear_r <= rise_frst & ~FAULT_ACTIVE
				& (SEQ_STATE == dsc_pkg::DSC_FAULTED); // RQ26
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			swon_r <= 1'b0;
			coast_r <= 1'b0;
			estop_r <= 1'b0;
			allow_ready_r <= 1'b0;
			op_go_r <= 1'b0;
		end else begin
			swon_r <= eff_r.power_up_request; // RQ5
			coast_r <= ~eff_r.coast_stop_inhibit; // RQ6
			estop_r <= ~eff_r.emergency_stop_inhibit; // RQ7
			allow_ready_r <= (SEQ_STATE == dsc_pkg::DSC_SW_DISABLED) & safe_ok
				& (~eff_r.power_up_request | eff_r.auto_init); // RQ14
			op_go_r <= (SEQ_STATE == dsc_pkg::DSC_SWITCHED_ON) & safe_ok
				& eff_r.power_up_request & op_req; // RQ15
		end
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			net_ref_r <= 1'b0;
			jog_r <= 1'b0;
			rev_r <= 1'b0;
		end else begin
			net_ref_r <= eff_r.net_ref; // RQ11
			jog_r <= eff_r.jog & eff_r.enable_op & in_op; // RQ12
			rev_r <= eff_r.reverse & eff_r.enable_op & in_op; // RQ13
		end
	end

	// status word, produced whatever the command channel; bit 9 shows the network channel
	always_comb begin
		stat_nxt = `DSC_STAT_RST; // RQ24
		stat_nxt[`DSC_S_RDY] = INIT_DONE & ~CONFIG_MODE; // RQ18
		stat_nxt[`DSC_S_SWON] = (SEQ_STATE == dsc_pkg::DSC_SWITCHED_ON) | in_op; // RQ19
		stat_nxt[`DSC_S_OPEN] = in_op; // RQ23
		stat_nxt[`DSC_S_FLT] = (SEQ_STATE == dsc_pkg::DSC_FAULT_REACT)
			| (SEQ_STATE == dsc_pkg::DSC_FAULTED); // RQ23
		stat_nxt[`DSC_S_VOLT] = supply_r; // RQ23
		stat_nxt[`DSC_S_NQS] = (SEQ_STATE != dsc_pkg::DSC_QSTOP); // RQ20
		stat_nxt[`DSC_S_DIS] = (SEQ_STATE == dsc_pkg::DSC_SW_DISABLED); // RQ21
		stat_nxt[`DSC_S_NET] = (src_r == dsc_pkg::DSC_SRC_NET); // RQ10
		stat_nxt[`DSC_S_JOG] = eff_r.jog; // RQ12
		stat_nxt[`DSC_S_REV] = eff_r.reverse; // RQ13
		stat_nxt[`DSC_S_REF] = eff_r.net_ref; // RQ11
		stat_nxt[`DSC_S_STOP] = (in_op & ~eff_r.enable_op)
			| (SEQ_STATE == dsc_pkg::DSC_QSTOP); // RQ22
	end

	always_ff @(posedge CLK_SYS) begin
		if (!NRST) begin
			stat_r <= `DSC_STAT_RST;
		end else begin
			stat_r <= stat_nxt; // RQ17
		end
	end

	assign EFFECTIVE_SEQUENCER_COMMAND = eff_r;
	assign SEQUENCER_STATE_FLAGS = stat_r;
	assign CMD_SOURCE = src_r;
	assign FAULT_RESET_PULSE = fault_pulse_r;
	assign FAULT_CLEAR = fault_clear_r;
	assign POWER_UP_REQUEST = swon_r;
	assign COAST_STOP = coast_r;
	assign EMERGENCY_STOP = estop_r;
	assign ALLOW_READY = allow_ready_r;
	assign ENABLE_OP_GO = op_go_r;
	assign NET_REF_SEL = net_ref_r;
	assign JOG_RUN = jog_r;
	assign REVERSE_RUN = rev_r;

	// checks
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!NRST);

	property p_net_mix;
		(!LOCAL_KEYPAD_SEL && APP_CMD[`DSC_C_NETCMD]) |=>
			(eff_r == (($past(NET_CMD) & ~SAFE) | ($past(NET_CMD) & $past(APP_CMD) & SAFE)));
	endproperty
	a_net_mix: assert property (p_net_mix) else $error("network word mix wrong"); // RQ2

	property p_app_pass;
		(!LOCAL_KEYPAD_SEL && !APP_CMD[`DSC_C_NETCMD]) |=> (eff_r == $past(APP_CMD));
	endproperty
	a_app_pass: assert property (p_app_pass) else $error("app word not passed"); // RQ3

	property p_keypad_mix;
		LOCAL_KEYPAD_SEL |=>
			(eff_r == (($past(LOCAL_KEYPAD_CMD) & ~SAFE) | ($past(APP_CMD) & SAFE)));
	endproperty
	a_keypad_mix: assert property (p_keypad_mix) else $error("keypad word mix wrong"); // RQ4

	property p_frst_edge;
		(eff_r[`DSC_C_FRST] && prev_r[`DSC_C_FRST]) |=> !FAULT_RESET_PULSE;
	endproperty
	a_frst_edge: assert property (p_frst_edge) else $error("reset on steady level"); // RQ9

	property p_frst_rise;
		$rose(eff_r[`DSC_C_FRST]) |=> FAULT_RESET_PULSE ##1 !FAULT_RESET_PULSE;
	endproperty
	a_frst_rise: assert property (p_frst_rise) else $error("reset pulse missing"); // RQ9

	property p_net_flag;
		(!LOCAL_KEYPAD_SEL && APP_CMD[`DSC_C_NETCMD]) |=> ##1 SEQUENCER_STATE_FLAGS[`DSC_S_NET];
	endproperty
	a_net_flag: assert property (p_net_flag) else $error("network flag missing"); // RQ10

	property p_dis_flag;
		$past(NRST) |-> (SEQUENCER_STATE_FLAGS[`DSC_S_DIS]
			== ($past(SEQ_STATE) == dsc_pkg::DSC_SW_DISABLED));
	endproperty
	a_dis_flag: assert property (p_dis_flag) else $error("disabled flag wrong"); // RQ21

	property p_edge_op;
		(eff_r.edge_run_required && eff_r.enable_op && prev_r.enable_op) |=> !ENABLE_OP_GO;
	endproperty
	a_edge_op: assert property (p_edge_op) else $error("level enabled operation"); // RQ15

	property p_fault_clear;
		FAULT_CLEAR |-> (FAULT_RESET_PULSE && !$past(FAULT_ACTIVE)
			&& $past(SEQ_STATE) == dsc_pkg::DSC_FAULTED);
	endproperty
	a_fault_clear: assert property (p_fault_clear) else $error("fault clear unjustified"); // RQ26

	property p_unused;
		(SEQUENCER_STATE_FLAGS & 16'h0d80) == 16'h0000;
	endproperty
	a_unused: assert property (p_unused) else $error("unused status bit set"); // RQ24

	property p_qs_flag;
		(SEQ_STATE == dsc_pkg::DSC_QSTOP) |=>
			!SEQUENCER_STATE_FLAGS[`DSC_S_NQS] && SEQUENCER_STATE_FLAGS[`DSC_S_STOP];
	endproperty
	a_qs_flag: assert property (p_qs_flag) else $error("quickstop flags wrong"); // RQ20

	property p_swon_out;
		$past(NRST) |-> (POWER_UP_REQUEST == $past(eff_r[`DSC_C_SWON]));
	endproperty
	a_swon_out: assert property (p_swon_out) else $error("switch-on output wrong"); // RQ5

	property p_coast_out;
		$past(NRST) |-> (COAST_STOP == !$past(eff_r[`DSC_C_ENVOLT]));
	endproperty
	a_coast_out: assert property (p_coast_out) else $error("coast stop output wrong"); // RQ6

	property p_estop_out;
		$past(NRST) |-> (EMERGENCY_STOP == !$past(eff_r[`DSC_C_NQS]));
	endproperty
	a_estop_out: assert property (p_estop_out) else $error("quickstop output wrong"); // RQ7

	property p_ref_flag;
		$past(NRST) |-> (NET_REF_SEL == $past(eff_r[`DSC_C_NETREF]))
			&& (SEQUENCER_STATE_FLAGS[`DSC_S_REF] == NET_REF_SEL);
	endproperty
	a_ref_flag: assert property (p_ref_flag) else $error("reference source wrong"); // RQ11

	property p_jog_run;
		JOG_RUN |-> $past(eff_r[`DSC_C_JOG] && eff_r[`DSC_C_ENOP])
			&& ($past(SEQ_STATE) == dsc_pkg::DSC_OP_ENABLED);
	endproperty
	a_jog_run: assert property (p_jog_run) else $error("jog without run"); // RQ12

	property p_rev_run;
		REVERSE_RUN |-> $past(eff_r[`DSC_C_REV] && eff_r[`DSC_C_ENOP])
			&& ($past(SEQ_STATE) == dsc_pkg::DSC_OP_ENABLED);
	endproperty
	a_rev_run: assert property (p_rev_run) else $error("reverse without run"); // RQ13

	property p_ready_go;
		ALLOW_READY |-> ($past(SEQ_STATE) == dsc_pkg::DSC_SW_DISABLED)
			&& $past(!eff_r[`DSC_C_SWON] || eff_r[`DSC_C_AUTOI]);
	endproperty
	a_ready_go: assert property (p_ready_go) else $error("ready allowed wrongly"); // RQ14

	property p_rdy_flag;
		$past(NRST) |-> (SEQUENCER_STATE_FLAGS[`DSC_S_RDY]
			== $past(INIT_DONE && !CONFIG_MODE));
	endproperty
	a_rdy_flag: assert property (p_rdy_flag) else $error("ready flag wrong"); // RQ18

	property p_swon_flag;
		$past(NRST) |-> (SEQUENCER_STATE_FLAGS[`DSC_S_SWON]
			== $past((SEQ_STATE == dsc_pkg::DSC_SWITCHED_ON)
			|| (SEQ_STATE == dsc_pkg::DSC_OP_ENABLED)));
	endproperty
	a_swon_flag: assert property (p_swon_flag) else $error("switched-on flag wrong"); // RQ19

	property p_stop_flag;
		$past(NRST) |-> (SEQUENCER_STATE_FLAGS[`DSC_S_STOP]
			== $past((SEQ_STATE == dsc_pkg::DSC_QSTOP)
			|| (SEQ_STATE == dsc_pkg::DSC_OP_ENABLED && !eff_r[`DSC_C_ENOP])));
	endproperty
	a_stop_flag: assert property (p_stop_flag) else $error("stopping flag wrong"); // RQ22

	c_run: cover property (eff_r == 16'hcc7f ##1 ENABLE_OP_GO);
	c_fault: cover property (FAULT_CLEAR);
	c_keypad: cover property (LOCAL_KEYPAD_SEL ##2 CMD_SOURCE == dsc_pkg::DSC_SRC_KEYPAD);
	c_ready: cover property (ALLOW_READY);
	c_jog_rev: cover property (JOG_RUN && REVERSE_RUN);
endmodule : dsc_core
`default_nettype wire

// *** core/dsc_core_end.sv ***
// spare design unit: the whole block sits in dsc_core

// *** testbench/dsc_far_model.sv ***
// far-side command sources: network, application and keypad
`timescale 1ns/1ps
`default_nettype none
module dsc_far_model (
	input wire logic CLK_SYS,
	output logic [15:0] APP_CMD,
	output logic [15:0] NET_CMD,
	output logic [15:0] LOCAL_KEYPAD_CMD,
	output logic LOCAL_KEYPAD_SEL
);
	initial begin
		APP_CMD = 16'h0000;
		NET_CMD = 16'h0000;
		LOCAL_KEYPAD_CMD = 16'h0000;
		LOCAL_KEYPAD_SEL = 1'b0;
	end
	// words change just after an edge and hold until the next call
	task automatic drive(input logic [15:0] a, input logic [15:0] n, input logic [15:0] k,
		input logic ks);
		@(posedge CLK_SYS);
		#1;
		APP_CMD = a | 16'h0070;
		NET_CMD = n | 16'h0070;
		LOCAL_KEYPAD_CMD = k | 16'h0070;
		LOCAL_KEYPAD_SEL = ks;
	endtask : drive
endmodule : dsc_far_model
`default_nettype wire

// *** testbench/dsc_core_test.sv ***
// self-checking testbench for the sequencer command and status block
`timescale 1ns/1ps
`default_nettype none
module dsc_core_test;
	logic clk_sys = 1'b0;
	logic nrst = 1'b0;
	logic init_done = 1'b0;
	logic config_mode = 1'b0;
	logic supply = 1'b0;
	logic fault_active = 1'b0;
	dsc_pkg::dsc_state_t seq_state = dsc_pkg::DSC_NOT_READY;
	logic [15:0] app, net, kp, eff, flags;
	logic sel, frp, fclr, pur, coast, estop, ardy, opgo, nref, jog, rev;
	dsc_pkg::dsc_src_t src;
	int err_count = 0;
	int checks = 0;
	initial begin
		forever #4 clk_sys = ~clk_sys;
	end
	dsc_far_model dsc_far_model_inst (.CLK_SYS(clk_sys), .APP_CMD(app), .NET_CMD(net),
		.LOCAL_KEYPAD_CMD(kp), .LOCAL_KEYPAD_SEL(sel));
	dsc_core dsc_core_inst (.CLK_SYS(clk_sys), .NRST(nrst), .LOCAL_KEYPAD_SEL(sel),
		.NET_CMD(net), .APP_CMD(app), .LOCAL_KEYPAD_CMD(kp), .SEQ_STATE(seq_state),
		.INIT_DONE(init_done), .CONFIG_MODE(config_mode), .SUPPLY_SENSE(supply),
		.FAULT_ACTIVE(fault_active), .EFFECTIVE_SEQUENCER_COMMAND(eff),
		.SEQUENCER_STATE_FLAGS(flags), .CMD_SOURCE(src), .FAULT_RESET_PULSE(frp),
		.FAULT_CLEAR(fclr), .POWER_UP_REQUEST(pur), .COAST_STOP(coast), .EMERGENCY_STOP(estop),
		.ALLOW_READY(ardy), .ENABLE_OP_GO(opgo), .NET_REF_SEL(nref), .JOG_RUN(jog),
		.REVERSE_RUN(rev));
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("mismatches %0d, comparisons %0d", err_count, checks);
		if (err_count == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : report_and_stop
	task automatic settle();
		repeat (3) @(posedge clk_sys);
		#1;
	endtask : settle
	task automatic set_in(input dsc_pkg::dsc_state_t s, input logic cfg, input logic fa);
		@(posedge clk_sys);
		#1;
		seq_state = s;
		config_mode = cfg;
		fault_active = fa;
	endtask : set_in
	task automatic put(input logic [15:0] a, input logic [15:0] n, input logic [15:0] k,
		input logic ks);
		dsc_far_model_inst.drive(a, n, k, ks);
		settle();
	endtask : put
	task automatic t_app();
		logic hit = 1'b0;
		set_in(dsc_pkg::DSC_SWITCHED_ON, 1'b0, 1'b0);
		put(16'h000f, 16'h0000, 16'h0000, 1'b0);
		check(eff, 16'h007f);
		check(16'(src), 16'(dsc_pkg::DSC_SRC_APP));
		check(16'(opgo), 16'h0001);
		check(flags & 16'h0203, 16'h0003);
		put(16'h800f, 16'h0000, 16'h0000, 1'b0);
		check(16'(opgo), 16'h0000);
		put(16'h8007, 16'h0000, 16'h0000, 1'b0);
		dsc_far_model_inst.drive(16'h800f, 16'h0000, 16'h0000, 1'b0);
		repeat (4) begin
			@(posedge clk_sys);
			#1;
			if (opgo === 1'b1) hit = 1'b1;
		end
		check(16'(hit), 16'h0001);
	endtask : t_app
	task automatic t_ready();
		set_in(dsc_pkg::DSC_SW_DISABLED, 1'b0, 1'b0);
		put(16'h0006, 16'h0000, 16'h0000, 1'b0);
		check(16'(ardy), 16'h0001);
		check(flags & 16'h0042, 16'h0040);
		put(16'h0007, 16'h0000, 16'h0000, 1'b0);
		check(16'(ardy), 16'h0000);
		put(16'h4007, 16'h0000, 16'h0000, 1'b0);
		check(16'(ardy), 16'h0001);
	endtask : t_ready
	task automatic t_net();
		logic [15:0] words [4] = '{16'hcc77, 16'hcc7f, 16'hcc7b, 16'hcc7d};
		logic [2:0] outs [4] = '{3'b100, 3'b100, 3'b101, 3'b110};
		set_in(dsc_pkg::DSC_SWITCHED_ON, 1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			put(16'h0477, words[i], 16'h0000, 1'b0);
			check(eff, words[i]);
			check(16'({pur, coast, estop}), 16'(outs[i]));
		end
		check(16'(src), 16'(dsc_pkg::DSC_SRC_NET));
		check(flags & 16'h4200, 16'h4200);
		check(16'(nref), 16'h0001);
		put(16'h0472, 16'hcc7f, 16'h0000, 1'b0);
		check(eff, 16'hcc7a);
	endtask : t_net
	task automatic t_keypad();
		set_in(dsc_pkg::DSC_OP_ENABLED, 1'b0, 1'b0);
		put(16'h0007, 16'h0000, 16'h3078, 1'b1);
		check(eff, 16'h307f);
		check(16'(src), 16'(dsc_pkg::DSC_SRC_KEYPAD));
		check(16'({jog, rev}), 16'h0003);
		check(flags & 16'hb000, 16'h3000);
		put(16'h0007, 16'h0000, 16'h3070, 1'b1);
		check(16'({jog, rev}), 16'h0000);
		check(flags & 16'h8d80, 16'h8000);
	endtask : t_keypad
	task automatic t_fault(input logic fa);
		set_in(dsc_pkg::DSC_FAULTED, 1'b0, fa);
		put(16'h0477, 16'hcc70, 16'h0000, 1'b0);
		dsc_far_model_inst.drive(16'h0477, 16'hccf0, 16'h0000, 1'b0);
		repeat (2) @(posedge clk_sys);
		#1;
		check(16'({frp, fclr}), 16'({1'b1, ~fa}));
		settle();
		check(16'({frp, fclr}), 16'h0000);
	endtask : t_fault
	task automatic t_status();
		put(16'h0007, 16'h0000, 16'h0000, 1'b0);
		for (int s = 0; s < 8; s++) begin
			set_in(dsc_pkg::dsc_state_t'(s), 1'b0, 1'b0);
			settle();
			check(flags & 16'h806f, {s == 4 || s == 5, 8'h00, s == 1, s != 5, 1'b0, s >= 6,
				s == 4, s == 3 || s == 4, 1'b1});
		end
		set_in(dsc_pkg::DSC_SW_DISABLED, 1'b1, 1'b0);
		settle();
		check(flags & 16'h0001, 16'h0000);
		supply = 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check(flags & 16'h0010, 16'h0000);
		settle();
		check(flags & 16'h0010, 16'h0010);
	endtask : t_status
	initial begin
		repeat (12) @(posedge clk_sys);
		#1;
		check(flags, 16'h0000);
		check(eff, 16'h0000);
		nrst = 1'b1;
		init_done = 1'b1;
		t_app();
		t_ready();
		t_net();
		t_keypad();
		t_fault(1'b0);
		t_fault(1'b1);
		t_status();
		report_and_stop();
	end
endmodule : dsc_core_test
`default_nettype wire
